// file: include/three_wire_pkg.sv
// constants, field layouts and carriers for the three-wire serial channel
// assumes a 32-bit axi4-lite register bus on a single 250 MHz clock
package three_wire_pkg;

    // register byte offsets
    localparam logic [7:0] MODE_OFS  = 8'h00;
    localparam logic [7:0] DATA_OFS  = 8'h04;
    localparam logic [7:0] RATE_OFS  = 8'h08;
    localparam logic [7:0] STAT_OFS  = 8'h0c;

    // mode register field positions
    localparam int TXE_POS   = 0;
    localparam int RXE_POS   = 1;
    localparam int INTCK_POS = 2;
    localparam int ORDER_POS = 3;

    // reset values
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] RATE_RST = 8'h00;

    // prescaler constants and bits per transfer
    localparam int          PRE_CNT_W = 5;
    localparam logic [4:0]  PRE_BASE  = 5'h10;
    localparam logic [3:0]  PRE_FAST  = 4'hf;
    localparam int          BITS      = 8;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN
    } xfer_state_t;

    typedef struct packed {
        logic [31:0] awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [31:0] araddr;
        logic        arvalid;
        logic        rready;
    } axil_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } axil_rsp_t;

    typedef struct packed {
        logic sck;
        logic sck_oe;
        logic sout;
    } serial_pins_t;

endpackage

// file: hw/rate_divider.sv
// tick generator: shift-clock half-period ticks from the rate register
// assumes aclk is the system clock; reset restarts the 5-bit counter
`timescale 1ns/1ns
`default_nettype none
module rate_divider
    import three_wire_pkg::*;
#(
    parameter int RATE_W = 8
)(
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // control
    input  wire logic [RATE_W-1:0] rate,
    input  wire logic              run,
    // tick
    output logic                   tick
);

    if (RATE_W < 4)
    begin : g_rate_w_bad
        $error("rate_divider: RATE_W below 4");
    end

    typedef struct packed {
        logic [PRE_CNT_W-1:0] cnt;
        logic                 tick;
    } div_state_t;

    div_state_t s_reg;
    div_state_t s_next;
    logic [PRE_CNT_W-1:0] limit;

    // ratio k+16 from the low four bits; k = 15 means divide by one
    always_comb
    begin
        limit  = PRE_BASE + {1'b0, rate[3:0]} - 5'h01;
        s_next = s_reg;
        s_next.tick = 1'b0;
        if (!run)
        begin
            s_next.cnt = '0;
        end
        else if (rate[3:0] == PRE_FAST || s_reg.cnt == limit)
        begin
            s_next.cnt  = '0;
            s_next.tick = 1'b1;
        end
        else
        begin
            s_next.cnt = s_reg.cnt + 5'h01;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign tick = s_reg.tick;

endmodule // rate_divider
`default_nettype wire

// file: hw/three_wire_serial_io.sv
// three-wire clocked serial channel with an axi4-lite register slave
// assumes one clock; serial pins are asynchronous and synchronised here
//
// What this block does
// - with transmit enabled, a write to the shift register starts a transfer
// - transmit enable clear keeps the data-out pin high
// - internal clock is driven out; bits leave on fall, sampled on rise
// - first falling edge may lag the start by up to one period
// - internal clock: transmit disable stops clock at next rise, no irq
// - external clock: edges before a start do nothing
// - external clock: transmit disable aborts, ignores clock, no irq
// - reception starts on receive enable rising or shift register read
// - internal clock: receive disable stops clock at next rise, no irq
// - external clock: no shift before start; receive disable aborts
// - both enables give full duplex, started by receive enable rise or write
// - clearing one enable aborts only that direction
// - internal clock: clearing both stops clock at next rise, aborts all
// - external clock: clearing both aborts all, ignores later clock
// - clearing both enables resets the serial bit counter
// - 5-bit prescaler divides by ratio from low four rate bits
// - each transfer is exactly eight bits in the set order
// - done flag on eighth rise; internal clock then held high
// - bit-order bit picks msb-first or lsb-first
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module three_wire_serial_io
    import three_wire_pkg::*;
#(
    parameter int RATE_W = 8
)(
    // clock and reset
    input  wire logic  aclk,
    input  wire logic  aresetn,
    // register bus
    input  wire axil_req_t bus_req,
    output axil_rsp_t      bus_rsp,
    // serial pins
    input  wire logic  serial_clock_pin_in,
    input  wire logic  serial_in_pin,
    output serial_pins_t   pins,
    // completion pulse
    output logic       transfer_done_irq
);

    if (RATE_W != 8)
    begin : g_rate_w_bad
        $error("three_wire_serial_io: RATE_W must be 8");
    end

    ////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        axil_rsp_t      rsp;
        logic           aw_held;
        logic [7:0]     aw_addr;
        logic           w_held;
        logic [31:0]    w_data;
        logic [3:0]     w_strb;
        logic [7:0]     mode;
        logic [7:0]     rate;
        logic [7:0]     shift;
        logic [2:0]     bit_cnt;
        xfer_state_t    state;
        logic           tx_on;
        logic           rx_on;
        logic           sck;
        logic           sck_oe;
        logic           sout;
        logic           done;
        logic           done_flag;
        logic           rxe_prev;
        logic [1:0]     sck_sync;
        logic [1:0]     sin_sync;
        logic           sck_prev;
    } top_state_t;

    top_state_t s_reg;
    top_state_t s_next;
    logic       tick;

    rate_divider #(
        .RATE_W (RATE_W)
    ) u_div (
        .aclk    (aclk),
        .aresetn (aresetn),
        .rate    (s_reg.rate),
        .run     (s_reg.state == ST_RUN && s_reg.mode[INTCK_POS]),
        .tick    (tick)
    );

    ////////////////////////////////////////////////////////////////////////

    logic       tx_en;
    logic       rx_en;
    logic       int_ck;
    logic       lsb_first;
    logic       wr_go;
    logic       rd_go;
    logic       data_wr;
    logic       data_rd;
    logic       start;
    logic       rise;
    logic       fall;
    logic       ext_rise;
    logic       ext_fall;
    logic [7:0] new_mode;
    logic [7:0] rd_val;
    logic       out_bit;

    always_comb
    begin
        s_next    = s_reg;
        tx_en     = s_reg.mode[TXE_POS];
        rx_en     = s_reg.mode[RXE_POS];
        int_ck    = s_reg.mode[INTCK_POS];
        lsb_first = s_reg.mode[ORDER_POS];
        new_mode  = s_reg.mode;
        rd_val    = 8'h00;
        data_wr   = 1'b0;
        data_rd   = 1'b0;
        rise      = 1'b0;
        fall      = 1'b0;

        // pin synchronisers; only the second stage is used by logic
        s_next.sck_sync = {s_reg.sck_sync[0], serial_clock_pin_in};
        s_next.sin_sync = {s_reg.sin_sync[0], serial_in_pin};
        s_next.sck_prev = s_reg.sck_sync[1];
        ext_rise = s_reg.sck_sync[1] && !s_reg.sck_prev;
        ext_fall = !s_reg.sck_sync[1] && s_reg.sck_prev;

        // bus handshakes: address and data taken in either order
        s_next.rsp.awready = 1'b0;
        s_next.rsp.wready  = 1'b0;
        s_next.rsp.arready = 1'b0;
        if (bus_req.awvalid && !s_reg.aw_held && !s_reg.rsp.awready)
        begin
            s_next.rsp.awready = 1'b1;
            s_next.aw_held     = 1'b1;
            s_next.aw_addr     = bus_req.awaddr[7:0];
        end
        if (bus_req.wvalid && !s_reg.w_held && !s_reg.rsp.wready)
        begin
            s_next.rsp.wready = 1'b1;
            s_next.w_held     = 1'b1;
            s_next.w_data     = bus_req.wdata;
            s_next.w_strb     = bus_req.wstrb;
        end
        if (s_reg.rsp.bvalid && bus_req.bready)
            s_next.rsp.bvalid = 1'b0;
        if (s_reg.rsp.rvalid && bus_req.rready)
            s_next.rsp.rvalid = 1'b0;

        wr_go = s_reg.aw_held && s_reg.w_held && !s_reg.rsp.bvalid;
        rd_go = bus_req.arvalid && !s_reg.rsp.arready && !s_reg.rsp.rvalid;

        if (wr_go)
        begin
            s_next.aw_held    = 1'b0;
            s_next.w_held     = 1'b0;
            s_next.rsp.bvalid = 1'b1;
            s_next.rsp.bresp  = RESP_OKAY;
            unique case (s_reg.aw_addr)
                MODE_OFS:
                begin
                    if (s_reg.w_strb[0])
                        new_mode = s_reg.w_data[7:0];
                end
                DATA_OFS:
                begin
                    data_wr = s_reg.w_strb[0];
                end
                RATE_OFS:
                begin
                    if (s_reg.w_strb[0])
                        s_next.rate = s_reg.w_data[7:0];
                end
                STAT_OFS:
                begin
                    // a finishing transfer later in this cycle wins
                    if (s_reg.w_strb[0] && s_reg.w_data[0])
                        s_next.done_flag = 1'b0;
                end
                default:
                begin
                    s_next.rsp.bresp = RESP_SLVERR;
                end
            endcase
        end

        if (rd_go)
        begin
            s_next.rsp.arready = 1'b1;
            s_next.rsp.rvalid  = 1'b1;
            s_next.rsp.rresp   = RESP_OKAY;
            unique case (bus_req.araddr[7:0])
                MODE_OFS:
                begin
                    rd_val = s_reg.mode;
                end
                DATA_OFS:
                begin
                    rd_val  = s_reg.shift;
                    data_rd = 1'b1;
                end
                RATE_OFS:
                begin
                    rd_val = s_reg.rate;
                end
                STAT_OFS:
                begin
                    rd_val = {6'h00, s_reg.state == ST_RUN,
                              s_reg.done_flag};
                end
                default:
                begin
                    s_next.rsp.rresp = RESP_SLVERR;
                end
            endcase
            s_next.rsp.rdata = {24'h000000, rd_val};
        end

        ////////////////////////////////////////////////////////////////////
        // serial engine

        s_next.mode     = new_mode;
        // one cycle behind mode, so a 0-to-1 change is seen once
        s_next.rxe_prev = s_reg.mode[RXE_POS];
        s_next.done     = 1'b0;

        if (data_wr)
            s_next.shift = s_reg.w_data[7:0];

        // starts: write with tx, rx enable rising, or read with rx and tx off
        start = (data_wr && tx_en)
              || (rx_en && !s_reg.rxe_prev)
              || (data_rd && rx_en && !tx_en);

        // internal clock toggles on prescaler ticks; fall first
        if (s_reg.state == ST_RUN && int_ck && tick)
        begin
            s_next.sck = !s_reg.sck;
            fall = s_reg.sck;
            rise = !s_reg.sck;
        end
        else if (s_reg.state == ST_RUN && !int_ck)
        begin
            fall = ext_fall;
            rise = ext_rise;
        end

        out_bit = lsb_first ? s_reg.shift[0] : s_reg.shift[7];

        unique case (s_reg.state)
            ST_IDLE:
            begin
                // edges before a start are ignored
                if (start)
                begin
                    s_next.state   = ST_RUN;
                    s_next.tx_on   = tx_en;
                    s_next.rx_on   = rx_en;
                    s_next.bit_cnt = 3'h0;
                    s_next.sck     = 1'b1;
                end
            end
            ST_RUN:
            begin
                // a cleared enable drops only its own direction
                if (!tx_en)
                    s_next.tx_on = 1'b0;
                if (!rx_en)
                    s_next.rx_on = 1'b0;
                if (fall && s_reg.tx_on && tx_en)
                    s_next.sout = out_bit;
                if (rise)
                begin
                    // shift register is always advanced; without rx it
                    // just shifts in pin data, contents undefined
                    s_next.shift = lsb_first
                        ? {s_reg.sin_sync[1], s_reg.shift[7:1]}
                        : {s_reg.shift[6:0], s_reg.sin_sync[1]};
                    s_next.bit_cnt = s_reg.bit_cnt + 3'h1;
                    if (!tx_en && !rx_en)
                    begin
                        s_next.state = ST_IDLE;
                        s_next.sck   = 1'b1;
                    end
                    else if (s_reg.bit_cnt == 3'(BITS - 1))
                    begin
                        s_next.state     = ST_IDLE;
                        s_next.sck       = 1'b1;
                        s_next.done      = 1'b1;
                        s_next.done_flag = 1'b1;
                    end
                end
                // external clock: abort immediately, later edges ignored
                if (!int_ck && !tx_en && !rx_en)
                begin
                    s_next.state   = ST_IDLE;
                    s_next.bit_cnt = 3'h0;
                    s_next.done    = 1'b0;
                    // park high, a later internal start must open on a fall
                    s_next.sck     = 1'b1;
                end
                else if (!tx_en && !rx_en)
                begin
                    s_next.bit_cnt = 3'h0;
                end
            end
        endcase

        // internal clock drives the pin whenever selected
        s_next.sck_oe = new_mode[INTCK_POS];
        if (!new_mode[TXE_POS])
            s_next.sout = 1'b1;
        if (start && tx_en && s_reg.state == ST_IDLE)
            s_next.sout = s_reg.sout; // held until first fall
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_reg          <= '0;
            s_reg.mode     <= MODE_RST;
            s_reg.rate     <= RATE_RST;
            s_reg.state    <= ST_IDLE;
            s_reg.sck      <= 1'b1;
            s_reg.sout     <= 1'b1;
            s_reg.sck_prev <= 1'b1;
            s_reg.sck_sync <= 2'b11;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    assign bus_rsp           = s_reg.rsp;
    assign pins.sck          = s_reg.sck;
    assign pins.sck_oe       = s_reg.sck_oe;
    assign pins.sout         = s_reg.sout;
    assign transfer_done_irq = s_reg.done;

endmodule // three_wire_serial_io
`default_nettype wire

// file: dv/serial_peer.sv
// far-side device model for the three-wire serial link
// assumes sck is the resolved clock line, idle high between frames
`timescale 1ns/1ns
`default_nettype none
module serial_peer
(
    // link
    input  wire logic       sck,
    input  wire logic       sout,
    output logic            sin,
    // bench side
    input  wire logic       clr,
    input  wire logic [7:0] tx_byte,
    output logic [7:0]      rx_byte
);
    int n = 0;
    initial sin = 1'b1;
    initial rx_byte = 8'h00;
    always @(posedge clr)
        n = 0;
    ////////////////////////////////////////////////////////////
    // next bit goes out on the fall
    always @(negedge sck)
        sin = tx_byte[7 - n];
    // takes a bit on each rise; line turns over after the frame,
    // late enough to clear the channel's input synchroniser
    always @(posedge sck)
    begin
        rx_byte = {rx_byte[6:0], sout};
        n = (n + 1) % 8;
        if (n == 0)
            sin <= #16 ~sin;
    end
endmodule // serial_peer
`default_nettype wire

// file: dv/three_wire_sva.sv
// port checks for the three-wire serial channel
// assumes mode and rate change only through bus writes
`timescale 1ns/1ns
`default_nettype none
module three_wire_sva
    import three_wire_pkg::*;
(
    // clock and reset
    input wire logic         aclk,
    input wire logic         aresetn,
    // register bus
    input wire axil_req_t    bus_req,
    input wire axil_rsp_t    bus_rsp,
    // serial side
    input wire logic         serial_clock_pin_in,
    input wire logic         serial_in_pin,
    input wire serial_pins_t pins,
    input wire logic         transfer_done_irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////
    // mirror of mode and rate; cycles with both enables clear
    logic       aw_take;
    logic [7:0] mode_reg;
    logic [7:0] rate_reg;
    logic [6:0] off_reg;
    assign aw_take = bus_req.awvalid && bus_rsp.awready;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode_reg <= MODE_RST;
            rate_reg <= RATE_RST;
            off_reg  <= '0;
        end
        else
        begin
            if (aw_take && bus_req.awaddr[7:0] == MODE_OFS)
                mode_reg <= bus_req.wdata[7:0];
            if (aw_take && bus_req.awaddr[7:0] == RATE_OFS)
                rate_reg <= bus_req.wdata[7:0];
            off_reg <= (mode_reg[1:0] != 2'b00) ? '0 :
                       off_reg + {6'h0, ~&off_reg};
        end
    end
    ////////////////////////////////////////////////////////////
    sequence s_tx_off;
        !mode_reg[TXE_POS] [*5];
    endsequence
    sequence s_clk_mode;
        $stable(mode_reg[INTCK_POS]) [*5];
    endsequence
    a_sout_off_high: assert property (s_tx_off |-> pins.sout)
        else $error("data out low with transmit off");
    a_abort_no_irq: assert property (off_reg > 7'd2 |-> !transfer_done_irq)
        else $error("done pulse after both enables cleared");
    a_abort_sck_stop: assert property (off_reg > 7'd70 |-> pins.sck)
        else $error("clock not parked high after abort");
    a_done_pulse: assert property (transfer_done_irq |=> !transfer_done_irq)
        else $error("done pulse longer than one cycle");
    a_done_sck_high: assert property
        (transfer_done_irq && pins.sck_oe |-> pins.sck)
        else $error("clock low at done");
    a_sck_rate_min: assert property
        (pins.sck_oe && $changed(pins.sck) && rate_reg[3:0] != 4'hf
         |=> $stable(pins.sck) [*8])
        else $error("clock half period too short");
    a_sck_drive_mode: assert property
        (s_clk_mode |-> pins.sck_oe == mode_reg[INTCK_POS])
        else $error("clock drive not matching mode");
    a_write_answer: assert property (aw_take |-> ##[1:2] bus_rsp.bvalid)
        else $error("no write response");
    a_read_answer: assert property
        (bus_req.arvalid && bus_rsp.arready
         |-> ##[0:1] (bus_rsp.rvalid && bus_rsp.rdata[31:8] == 24'h0))
        else $error("bad read answer");
    a_bad_read: assert property
        (bus_req.arvalid && bus_rsp.arready && bus_req.araddr[7:0] > STAT_OFS
         |-> ##[0:1] (bus_rsp.rvalid && bus_rsp.rresp == RESP_SLVERR))
        else $error("unmapped read not refused");
endmodule // three_wire_sva
bind three_wire_serial_io three_wire_sva chk_u (
    .aclk(aclk), .aresetn(aresetn), .bus_req(bus_req), .bus_rsp(bus_rsp),
    .serial_clock_pin_in(serial_clock_pin_in),
    .serial_in_pin(serial_in_pin), .pins(pins),
    .transfer_done_irq(transfer_done_irq)
);
`default_nettype wire

// file: dv/testbench.sv
// self-checking bench for the three-wire serial channel
// assumes serial_peer on the link and the bound port checker
`timescale 1ns/1ns
`default_nettype none
module testbench
    import three_wire_pkg::*;
;
    logic         aclk = 1'b0;
    logic         aresetn = 1'b0;
    axil_req_t    req = '0;
    axil_rsp_t    rsp;
    serial_pins_t pins;
    logic         irq;
    logic         ext_sck = 1'b1;
    logic         sck_line;
    logic         sin;
    logic         pclr = 1'b0;
    logic [7:0]   ptx = 8'h00;
    logic [7:0]   prx;
    int           num_errors = 0;
    int           total_checks = 0;
    int           seed = 84;
    int           irq_seen = 0;
    int           exp_irq = 0;
    always #2 aclk = ~aclk;
    assign sck_line = pins.sck_oe ? pins.sck : ext_sck;
    always @(negedge aclk)
        if (irq === 1'b1)
            irq_seen++;
    three_wire_serial_io dut_u (
        .aclk(aclk), .aresetn(aresetn), .bus_req(req), .bus_rsp(rsp),
        .serial_clock_pin_in(sck_line), .serial_in_pin(sin),
        .pins(pins), .transfer_done_irq(irq)
    );
    serial_peer peer_u (
        .sck(sck_line), .sout(pins.sout), .sin(sin),
        .clr(pclr), .tx_byte(ptx), .rx_byte(prx)
    );
    ////////////////////////////////////////////////////////////
    function automatic logic [7:0] rev(input logic [7:0] v);
        for (int i = 0; i < 8; i++)
            rev[i] = v[7 - i];
    endfunction
    task automatic chk(input string n, input logic [31:0] e, s);
        total_checks++;
        if (s !== e)
        begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic tmo(input int t);
        if (t >= 2000)
        begin
            $display("FAIL wait expected done seen timeout");
            num_errors++;
            conclude();
        end
    endtask
    // response sampled at the falling edge, acted on at the rise
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int t;
        logic aw;
        logic w;
        logic b;
        req.awaddr <= {24'h0, a};
        req.wdata <= {24'h0, d};
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        for (t = 0; t < 2000; t++)
        begin
            @(negedge aclk);
            aw = rsp.awready;
            w = rsp.wready;
            b = rsp.bvalid;
            @(posedge aclk);
            if (aw)
                req.awvalid <= 1'b0;
            if (w)
                req.wvalid <= 1'b0;
            if (b)
                break;
        end
        tmo(t);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        int t;
        logic ar;
        logic v;
        req.araddr <= {24'h0, a};
        req.arvalid <= 1'b1;
        for (t = 0; t < 2000; t++)
        begin
            @(negedge aclk);
            ar = rsp.arready;
            v = rsp.rvalid;
            d = rsp.rdata;
            r = rsp.rresp;
            @(posedge aclk);
            if (ar)
                req.arvalid <= 1'b0;
            if (v)
                break;
        end
        tmo(t);
    endtask
    task automatic pulse(input int n);
        repeat (n)
        begin
            repeat (10) @(posedge aclk);
            ext_sck <= 1'b0;
            repeat (10) @(posedge aclk);
            ext_sck <= 1'b1;
        end
    endtask
    task automatic look(input string n);
        @(negedge aclk);
        chk({n, " irq"}, exp_irq, irq_seen);
        chk({n, " sout"}, 1, pins.sout);
        chk({n, " sck"}, 1, pins.sck);
        @(posedge aclk);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic xfer(input logic [7:0] m, input bit first);
        logic [7:0]  d;
        logic [7:0]  w;
        logic [31:0] r;
        logic [1:0]  rs;
        int          t;
        d = 8'($random(seed));
        w = 8'($random(seed));
        ptx <= w;
        pclr <= 1'b1;
        if (first)
            wr(MODE_OFS, 8'h00);
        wr(DATA_OFS, d);
        pclr <= 1'b0;
        if (first)
            wr(MODE_OFS, m);
        exp_irq++;
        if (!m[INTCK_POS])
            pulse(8);
        for (t = 0; t < 2000 && irq_seen != exp_irq; t++)
            @(posedge aclk);
        tmo(t);
        rd(DATA_OFS, r, rs);
        // without transmit the data-out line stays high all frame
        chk("peer rx", {24'h0, m[0] ? (m[3] ? rev(d) : d) : 8'hff}, {24'h0, prx});
        chk("shift reg", {24'h0, m[3] ? rev(w) : w}, r);
    endtask
    initial
    begin
        int          k;
        logic [31:0] r;
        logic [1:0]  rs;
        req.bready = 1'b1;
        req.rready = 1'b1;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        k = {$random(seed)} % 15;
        wr(RATE_OFS, k[7:0]);
        rd(RATE_OFS, r, rs);
        chk("rate", k, r);
        rd(8'h40, r, rs);
        chk("bad resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
        wr(MODE_OFS, 8'h01);
        pulse(8);
        look("idle");
        wr(MODE_OFS, 8'h03);
        pulse(3);
        wr(MODE_OFS, 8'h00);
        pulse(5);
        look("ext abort");
        // clock source and bit order, three back-to-back each
        for (int i = 0; i < 4; i++)
            for (int j = 0; j < 3; j++)
                xfer({4'h0, i[1:0], 2'b11}, j == 0);
        wr(DATA_OFS, 8'h5a);
        repeat (40) @(posedge aclk);
        // internal clock stays selected; both enables and the bit-order bit drop
        wr(MODE_OFS, 8'h04);
        repeat (150) @(posedge aclk);
        look("int abort");
        xfer(8'h07, 1'b1);
        xfer(8'h06, 1'b1);
        // the data read with receive only starts one more reception
        exp_irq++;
        for (k = 0; k < 2000 && irq_seen != exp_irq; k++)
            @(posedge aclk);
        tmo(k);
        look("read start");
        conclude();
    end
endmodule // testbench
`default_nettype wire
